// [hdl/dsw_pkg.sv]
package dsw_pkg;

  // ************************************************************
  // Frame layout
  // ************************************************************
  localparam int unsigned FRAME_BITS     = 24;
  localparam int unsigned CODE_BITS      = 16;
  localparam int unsigned PD_HI_POS      = 17;
  localparam int unsigned PD_LO_POS      = 16;
  localparam int unsigned LEAD_ZERO_MSB  = 23;
  localparam int unsigned LEAD_ZERO_LSB  = 18;
  localparam int unsigned REF_EXTRA_EDGES = 2;
  localparam logic [4:0]  EDGE_CNT_MAX   = 5'h1F;

  // ************************************************************
  // Reset values and commands
  // ************************************************************
  localparam logic [15:0] CODE_RESET     = 16'h0000;
  localparam logic [1:0]  MODE_RESET     = 2'h0;
  localparam logic        REF_EN_RESET   = 1'b1;
  // Fixed reference-disable word
  localparam logic [23:0] REF_OFF_WORD   = 24'h490401;
  // Two-step re-enable words; patterns left open, neutral defaults
  localparam logic [23:0] REF_ON_WORD_A  = 24'hFC0000;
  localparam logic [23:0] REF_ON_WORD_B  = 24'hFC0001;

  // ************************************************************
  // Power modes
  // ************************************************************
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_PD_1K  = 2'h1;
  localparam logic [1:0] MODE_PD_100K = 2'h2;
  localparam logic [1:0] MODE_PD_HIZ = 2'h3;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int unsigned CLK_PERIOD_NS   = 50;
  localparam int unsigned SEL_HIGH_MIN_NS = 33;
  // Least time rounds up, never below one cycle
  localparam int unsigned SEL_HIGH_CYC_I  =
    (SEL_HIGH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0]  SEL_HIGH_CYC    = 4'(SEL_HIGH_CYC_I < 1 ? 1 : SEL_HIGH_CYC_I);
  localparam int unsigned SCLK_MAX_MHZ    = 30;
  // Host divider: top count of the half-period divider; a link-clock half period lasts three system cycles
  localparam logic [3:0]  HALF_PERIOD_CYC = 4'h2;

  // ************************************************************
  // Host register map
  // ************************************************************
  localparam logic [1:0]  ADDR_WORD       = 2'h0;
  localparam logic [1:0]  ADDR_CTRL       = 2'h1;
  localparam logic [1:0]  ADDR_STAT       = 2'h2;
  // Control word: extra edges in the low bits, start flag here
  localparam int unsigned CTRL_GO_POS     = 8;

endpackage

// [hdl/dsw_link_if.sv]
interface dsw_link_if;
  logic frame_sel_n;
  logic sclk;
  logic sdata;

  modport host (output frame_sel_n, output sclk, output sdata);
  modport dev  (input  frame_sel_n, input  sclk, input  sdata);
endinterface

// [hdl/dsw_device.sv]
// What this block does
// - Host opens frames with select falling edge.
// - Shift data in on each falling clock.
// - Execute assembled word on 24th edge.
// - Host holds select high 33ns between frames.
// - Host sends six zeros, then mode bits.
// - Last 16 bits load converter code.
// - Mode bits pick normal or power-down load.
// - Power-down disconnects amplifier, powers analog off.
// - Power-down keeps stored converter code.
// - Early select rise clears shift register.
// - Aborted frame changes neither code nor mode.
// - Power-up clears registers, output at zero.
// - Reference enabled after power-up by default.
// - Host sends disable word, 26 clocks low.
// - Host adds two edges after reference word.
// - Reference re-enabled by reset or pair.
// - Reference off tri-states pin, conversion continues.
// - Host keeps serial clock at most 30MHz.
// - Frames travel most significant bit first.
// - Code is straight unsigned binary.
//
// The address-and-strobe port and the placing of the registers were chosen for this implementation.
module dsw_device (
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  dsw_link_if.dev          link,
  output logic [15:0]      dac_code_o,
  output logic [1:0]       power_mode_o,
  output logic             amp_connect_o,
  output logic             analog_on_o,
  output logic             load_1k_o,
  output logic             load_100k_o,
  output logic             ref_enable_o,
  output logic             ref_pin_oe_o,
  output logic             frame_done_o,
  output logic             frame_abort_o
);

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic [2:0]  sel_sync;
    logic [2:0]  sclk_sync;
    logic [2:0]  din_sync;
    logic        sel_stable;
    logic        sclk_stable;
    logic        in_frame;
    logic        executed;
    logic [4:0]  edge_cnt;
    logic [23:0] shift;
    logic [23:0] held_word;
    logic        ref_step_a;
    logic [15:0] code;
    logic [1:0]  mode;
    logic        ref_en;
    logic        done;
    logic        abort;
    logic [15:0] out_code;
    logic [1:0]  out_mode;
    logic        out_amp;
    logic        out_analog;
    logic        out_load_1k;
    logic        out_load_100k;
    logic        out_ref;
    logic        out_ref_oe;
    logic        out_done;
    logic        out_abort;
  } dsw_dev_s;

  dsw_dev_s st_q;
  dsw_dev_s st_d;
  logic     sel_fall;
  logic     sel_rise;
  logic     sclk_fall;
  logic     din_bit;
  logic [23:0] word_now;

  // ************************************************************
  // Pin edges
  // ************************************************************
  // A level counts once stages two and three agree, so a one-cycle glitch never makes an edge
  function automatic logic agreed_edge(logic [2:0] sync, logic stable, logic level);
    agreed_edge = (stable != level) && (sync[1] == sync[2]) && (sync[2] == level);
  endfunction

  // Edge strobes; data is read from the same stage as the clock, so both keep step
  always_comb begin
    sel_fall  = agreed_edge(st_q.sel_sync, st_q.sel_stable, 1'b0);
    sel_rise  = agreed_edge(st_q.sel_sync, st_q.sel_stable, 1'b1);
    sclk_fall = agreed_edge(st_q.sclk_sync, st_q.sclk_stable, 1'b0);
    din_bit   = st_q.din_sync[2];
    word_now  = {st_q.shift[22:0], din_bit};
  end

  // ************************************************************
  // Next state
  // ************************************************************
  // Ref commands act when the frame closes, since only then is the count of extra edges complete
  always_comb begin
    st_d = st_q;
    st_d.done  = 1'b0;
    st_d.abort = 1'b0;
    st_d.sel_sync  = {st_q.sel_sync[1:0], link.frame_sel_n};
    st_d.sclk_sync = {st_q.sclk_sync[1:0], link.sclk};
    st_d.din_sync  = {st_q.din_sync[1:0], link.sdata};
    if (st_q.sel_sync[1] == st_q.sel_sync[2]) begin
      st_d.sel_stable = st_q.sel_sync[2];
    end
    if (st_q.sclk_sync[1] == st_q.sclk_sync[2]) begin
      st_d.sclk_stable = st_q.sclk_sync[2];
    end
    if (sel_fall) begin
      st_d.in_frame = 1'b1;
      st_d.executed = 1'b0;
      st_d.edge_cnt = 5'h00;
      st_d.shift    = 24'h000000;
    end else if (sel_rise) begin
      if (st_q.in_frame && !st_q.executed) begin
        st_d.abort = 1'b1;
      end
      if (st_q.executed && st_q.edge_cnt >= 5'(dsw_pkg::FRAME_BITS + dsw_pkg::REF_EXTRA_EDGES)) begin
        if (st_q.held_word == dsw_pkg::REF_OFF_WORD) begin
          st_d.ref_en     = 1'b0;
          st_d.ref_step_a = 1'b0;
        end else if (st_q.held_word == dsw_pkg::REF_ON_WORD_A) begin
          st_d.ref_step_a = 1'b1;
        end else if (st_q.held_word == dsw_pkg::REF_ON_WORD_B && st_q.ref_step_a) begin
          st_d.ref_en     = 1'b1;
          st_d.ref_step_a = 1'b0;
        end else begin
          st_d.ref_step_a = 1'b0;
        end
      end
      st_d.in_frame = 1'b0;
      st_d.shift    = 24'h000000;
    end else if (sclk_fall && st_q.in_frame) begin
      if (st_q.edge_cnt != dsw_pkg::EDGE_CNT_MAX) begin
        st_d.edge_cnt = st_q.edge_cnt + 5'h01;
      end
      if (!st_q.executed) begin
        st_d.shift = word_now;
        if (st_q.edge_cnt == 5'(dsw_pkg::FRAME_BITS - 1)) begin
          // Extra edges after this point never touch code or mode
          st_d.executed  = 1'b1;
          st_d.held_word = word_now;
          st_d.done      = 1'b1;
          // Reference words are commands, not data loads
          if (word_now != dsw_pkg::REF_OFF_WORD && word_now != dsw_pkg::REF_ON_WORD_A &&
              word_now != dsw_pkg::REF_ON_WORD_B) begin
            st_d.mode = word_now[dsw_pkg::PD_HI_POS -: 2];
            if (word_now[dsw_pkg::PD_HI_POS -: 2] == dsw_pkg::MODE_NORMAL) begin
              st_d.code = word_now[dsw_pkg::CODE_BITS-1:0];
            end
          end
        end
      end
    end
    // Analog-facing controls trail the state one register, so every port leaves a flip-flop
    st_d.out_code      = st_q.code;
    st_d.out_mode      = st_q.mode;
    st_d.out_amp       = st_q.mode == dsw_pkg::MODE_NORMAL;
    st_d.out_analog    = st_q.mode == dsw_pkg::MODE_NORMAL;
    st_d.out_load_1k   = st_q.mode == dsw_pkg::MODE_PD_1K;
    st_d.out_load_100k = st_q.mode == dsw_pkg::MODE_PD_100K;
    st_d.out_ref       = st_q.ref_en;
    st_d.out_ref_oe    = st_q.ref_en;
    st_d.out_done      = st_q.done;
    st_d.out_abort     = st_q.abort;
  end

  // ************************************************************
  // Registers
  // ************************************************************
  // Reset stands in for power-on: code and mode zero, select seen high, amplifier, analog and reference on
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      st_q <= '0;
      st_q.sel_sync   <= 3'h7;
      st_q.sel_stable <= 1'b1;
      st_q.code       <= dsw_pkg::CODE_RESET;
      st_q.mode       <= dsw_pkg::MODE_RESET;
      st_q.ref_en     <= dsw_pkg::REF_EN_RESET;
      st_q.out_code   <= dsw_pkg::CODE_RESET;
      st_q.out_mode   <= dsw_pkg::MODE_RESET;
      st_q.out_amp    <= 1'b1;
      st_q.out_analog <= 1'b1;
      st_q.out_ref    <= dsw_pkg::REF_EN_RESET;
      st_q.out_ref_oe <= dsw_pkg::REF_EN_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  // Plain copies of state bits, so nothing combinational reaches the pins
  assign dac_code_o    = st_q.out_code;
  assign power_mode_o  = st_q.out_mode;
  assign amp_connect_o = st_q.out_amp;
  assign analog_on_o   = st_q.out_analog;
  assign load_1k_o     = st_q.out_load_1k;
  assign load_100k_o   = st_q.out_load_100k;
  assign ref_enable_o  = st_q.out_ref;
  assign ref_pin_oe_o  = st_q.out_ref_oe;
  assign frame_done_o  = st_q.out_done;
  assign frame_abort_o = st_q.out_abort;

endmodule

// [hdl/dsw_host.sv]
module dsw_host (
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  dsw_link_if.host         link,
  input  wire logic [1:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic [31:0]      rdata_o
);

  // ************************************************************
  // Registers: 0 word, 1 extra edges + go, 2 status
  // ************************************************************
  typedef enum logic [3:0] {
    H_IDLE  = 4'b0001,
    H_LOW   = 4'b0010,
    H_HIGH  = 4'b0100,
    H_GAP   = 4'b1000
  } dsw_host_e;

  typedef struct packed {
    dsw_host_e   state;
    logic [23:0] word;
    logic [23:0] shift;
    logic [2:0]  extra;
    logic [4:0]  left;
    logic [3:0]  div;
    logic        sel_n;
    logic        sclk;
    logic        sdata;
    logic        busy;
    logic [31:0] rdata;
  } dsw_host_s;

  dsw_host_s st_q;
  dsw_host_s st_d;

  // Bus, then the frame engine; SCLK half period limits rate
  always_comb begin
    st_d = st_q;
    st_d.rdata = 32'h00000000;
    if (rd_i) begin
      if (addr_i == dsw_pkg::ADDR_WORD) begin
        st_d.rdata = {8'h00, st_q.word};
      end else if (addr_i == dsw_pkg::ADDR_CTRL) begin
        st_d.rdata = {29'h0, st_q.extra};
      end else if (addr_i == dsw_pkg::ADDR_STAT) begin
        st_d.rdata = {31'h0, st_q.busy};
      end
    end
    if (wr_i && addr_i == dsw_pkg::ADDR_WORD) begin
      st_d.word = wdata_i[23:0];
    end
    if (wr_i && addr_i == dsw_pkg::ADDR_CTRL && !st_q.busy) begin
      st_d.extra = wdata_i[2:0];
      if (wdata_i[dsw_pkg::CTRL_GO_POS]) begin
        st_d.busy  = 1'b1;
        st_d.sel_n = 1'b0;
        st_d.shift = st_q.word;
        st_d.sdata = st_q.word[23];
        st_d.left  = 5'(dsw_pkg::FRAME_BITS) + {2'h0, wdata_i[2:0]};
        st_d.div   = 4'h0;
        st_d.state = H_LOW;
      end
    end
    case (st_q.state)
      H_LOW: begin
        st_d.div = st_q.div + 4'h1;
        if (st_q.div == dsw_pkg::HALF_PERIOD_CYC) begin
          // Data moves with the rising edge, so it has settled at the falling edge that samples it
          st_d.div   = 4'h0;
          st_d.sclk  = 1'b1;
          st_d.sdata = st_q.shift[23];
          st_d.shift = {st_q.shift[22:0], 1'b0};
          st_d.state = H_HIGH;
        end
      end
      H_HIGH: begin
        st_d.div = st_q.div + 4'h1;
        if (st_q.div == dsw_pkg::HALF_PERIOD_CYC) begin
          st_d.div   = 4'h0;
          st_d.sclk  = 1'b0;
          st_d.left  = st_q.left - 5'h01;
          st_d.state = H_LOW;
          if (st_q.left == 5'h01) begin
            st_d.state = H_GAP;
          end
        end
      end
      H_GAP: begin
        st_d.sdata = st_q.shift[23];
        st_d.div   = st_q.div + 4'h1;
        if (st_q.div == dsw_pkg::HALF_PERIOD_CYC) begin
          st_d.sel_n = 1'b1;
        end
        if (st_q.div == dsw_pkg::HALF_PERIOD_CYC + dsw_pkg::SEL_HIGH_CYC) begin
          st_d.busy  = 1'b0;
          st_d.state = H_IDLE;
        end
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      st_q       <= '0;
      st_q.state <= H_IDLE;
      st_q.sel_n <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  assign link.frame_sel_n = st_q.sel_n;
  assign link.sclk        = st_q.sclk;
  assign link.sdata       = st_q.sdata;
  assign rdata_o          = st_q.rdata;

endmodule

// [dv/dsw_link_props.sv]
module dsw_link_props (
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        frame_sel_n,
  input  wire logic        sclk,
  input  wire logic [15:0] dac_code_o,
  input  wire logic [1:0]  power_mode_o,
  input  wire logic        amp_connect_o,
  input  wire logic        analog_on_o,
  input  wire logic        load_1k_o,
  input  wire logic        load_100k_o,
  input  wire logic        ref_enable_o,
  input  wire logic        ref_pin_oe_o,
  input  wire logic        frame_done_o
);
  logic [4:0] falls_q;
  logic       sclk_q;
  logic       sel_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  // ********
  // Falls seen on the wire in this frame
  // ********
  always_ff @(posedge clk_i) begin
    sclk_q <= sclk;
    sel_q  <= frame_sel_n;
    // Cleared at the select fall, so the count still stands when the device answers late
    if (sys_rst_i || (sel_q && !frame_sel_n)) begin
      falls_q <= 5'h00;
    end else if (!frame_sel_n && sclk_q && !sclk && falls_q != 5'h1F) begin
      falls_q <= falls_q + 5'h01;
    end
  end

  // ********
  // Link and device relations
  // ********
  property p_sclk_idle; frame_sel_n |-> !sclk; endproperty
  a_sclk_idle: assert property (p_sclk_idle) else $error("sclk moved outside frame");
  property p_sclk_high; $rose(sclk) |=> sclk; endproperty
  a_sclk_high: assert property (p_sclk_high) else $error("sclk high too short");
  property p_done_at_24; $rose(frame_done_o) |-> falls_q inside {5'h18, 5'h19}; endproperty
  a_done_at_24: assert property (p_done_at_24) else $error("done not at 24th fall");
  property p_code_at_24; $changed(dac_code_o) |-> falls_q inside {5'h18, 5'h19}; endproperty
  a_code_at_24: assert property (p_code_at_24) else $error("code moved off commit");
  property p_pd_amp;
    $stable(power_mode_o) |-> {amp_connect_o, analog_on_o} == {2{power_mode_o == dsw_pkg::MODE_NORMAL}};
  endproperty
  a_pd_amp: assert property (p_pd_amp) else $error("amplifier state wrong for mode");
  property p_load_sel;
    $stable(power_mode_o) |-> load_1k_o == (power_mode_o == dsw_pkg::MODE_PD_1K)
      && load_100k_o == (power_mode_o == dsw_pkg::MODE_PD_100K);
  endproperty
  a_load_sel: assert property (p_load_sel) else $error("load select wrong for mode");
  property p_ref_pin; $stable(ref_enable_o) |-> ref_pin_oe_o == ref_enable_o; endproperty
  a_ref_pin: assert property (p_ref_pin) else $error("reference pin drive mismatch");
  property p_pd_code;
    $past(power_mode_o) != dsw_pkg::MODE_NORMAL && power_mode_o != dsw_pkg::MODE_NORMAL |-> $stable(dac_code_o);
  endproperty
  a_pd_code: assert property (p_pd_code) else $error("code moved in power-down");
endmodule

// [dv/tb_top.sv]
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_i     = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic [1:0]  addr_i    = 2'h0;
  logic [31:0] wdata_i   = 32'h0;
  logic        wr_i      = 1'b0;
  logic        rd_i      = 1'b0;
  logic [31:0] rdata_o, rd_v;
  logic [15:0] dac_code_o, code_b, code_x, c;
  logic [1:0]  power_mode_o, mode_b, m;
  logic        amp_connect_o, analog_on_o, load_1k_o, load_100k_o;
  logic        ref_enable_o, ref_pin_oe_o, frame_done_o, done_d, done_b, abort_b;
  logic [17:0] exp_q[$];
  int          num_errors = 0;
  int          tests_run  = 0;

  dsw_link_if link();
  dsw_link_if link_b();
  dsw_host i_dsw_host (.clk_i, .sys_rst_i, .link, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o);
  dsw_device i_dsw_device (.clk_i, .sys_rst_i, .link, .dac_code_o, .power_mode_o, .amp_connect_o, .analog_on_o,
    .load_1k_o, .load_100k_o, .ref_enable_o, .ref_pin_oe_o, .frame_done_o, .frame_abort_o());
  // Second device faces the bench, which breaks the framing on purpose
  dsw_device i_dsw_device_b (.clk_i, .sys_rst_i, .link(link_b), .dac_code_o(code_b), .power_mode_o(mode_b),
    .amp_connect_o(), .analog_on_o(), .load_1k_o(), .load_100k_o(), .ref_enable_o(), .ref_pin_oe_o(),
    .frame_done_o(done_b), .frame_abort_o(abort_b));
  dsw_link_props i_dsw_link_props (.clk_i, .sys_rst_i, .frame_sel_n(link.frame_sel_n), .sclk(link.sclk),
    .dac_code_o, .power_mode_o, .amp_connect_o, .analog_on_o, .load_1k_o, .load_100k_o, .ref_enable_o,
    .ref_pin_oe_o, .frame_done_o);

  // ********
  // Bench tasks
  // ********
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    tests_run++;
    if (exp !== got) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic results();
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // One strobe cycle; read data caught in the cycle after
  task automatic bus(logic wr, logic [1:0] a, logic [31:0] d);
    @(posedge clk_i);
    wr_i    <= wr;
    rd_i    <= ~wr;
    addr_i  <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
    rd_i <= 1'b0;
    #1 rd_v = rdata_o;
  endtask
  // Code register only follows frames in normal mode
  task automatic note(logic [1:0] md, logic [15:0] cd);
    if (md == dsw_pkg::MODE_NORMAL) code_x = cd;
    exp_q.push_back({md, code_x});
  endtask
  task automatic send(logic [23:0] w, logic [2:0] extra);
    int n = 0;
    bus(1'b1, 2'h0, {8'h00, w});
    bus(1'b1, 2'h1, {23'h0, 1'b1, 5'h00, extra});
    do begin
      bus(1'b0, 2'h2, 32'h0);
      n++;
    end while (rd_v[0] !== 1'b0 && n < 400);
    if (rd_v[0] !== 1'b0) begin
      num_errors++;
      results();
    end
    bus(1'b0, 2'h0, 32'h0);
    chk("word_rb", {8'h00, w}, rd_v);
    repeat (10) @(posedge clk_i);
  endtask
  // Hand-made frame, MSB first, 400 ns link clock; data flips once select is released
  task automatic bang(logic [23:0] w, int falls);
    @(posedge clk_i);
    link_b.frame_sel_n <= 1'b0;
    for (int i = 0; i < falls; i++) begin
      repeat (4) @(posedge clk_i);
      link_b.sclk  <= 1'b1;
      link_b.sdata <= w[23-i];
      repeat (4) @(posedge clk_i);
      link_b.sclk <= 1'b0;
    end
    repeat (4) @(posedge clk_i);
    link_b.frame_sel_n <= 1'b1;
    link_b.sdata       <= ~link_b.sdata;
  endtask
  task automatic await_b(logic want_done);
    int n = 0;
    while ((want_done ? done_b : abort_b) !== 1'b1 && n < 50) begin
      @(posedge clk_i);
      n++;
    end
    chk("pulse_b", 32'h1, 32'(n < 50));
    if (n >= 50) results();
    repeat (3) @(posedge clk_i);
  endtask

  initial begin
    forever #25 clk_i = ~clk_i;
  end

  // Oldest note against the committed state, a cycle after done
  always @(posedge clk_i) begin
    done_d <= frame_done_o;
    if (done_d === 1'b1 && exp_q.size() > 0) begin
      chk("code_mode", {14'h0, exp_q.pop_front()}, {14'h0, power_mode_o, dac_code_o});
    end
  end

  // ********
  // Main sequence
  // ********
  initial begin
    link_b.frame_sel_n = 1'b1;
    link_b.sclk        = 1'b0;
    link_b.sdata       = 1'b0;
    void'($urandom(32'h0A3E9EAE));
    repeat (20) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk("reset", 32'h3, 32'({power_mode_o, dac_code_o, ref_enable_o, amp_connect_o}));
    // Every mode in turn, random codes, boundary codes, random trailing edges
    for (int i = 0; i < 9; i++) begin
      m = i[1:0];
      c = (i == 4) ? 16'hFFFF : 16'($urandom());
      if (i == 8) c = 16'h0000;
      note(m, c);
      send({6'h00, m, c}, 3'($urandom_range(4)));
    end
    send(dsw_pkg::REF_OFF_WORD, 3'h1);
    chk("ref_short", 32'h1, {31'h0, ref_enable_o});
    send(dsw_pkg::REF_OFF_WORD, 3'h2);
    chk("ref_off", 32'h0, 32'({ref_enable_o, ref_pin_oe_o}));
    note(2'h0, 16'h5AA5);
    send({8'h00, 16'h5AA5}, 3'h0);
    send(dsw_pkg::REF_ON_WORD_A, 3'h2);
    send(dsw_pkg::REF_ON_WORD_B, 3'h2);
    chk("ref_on", 32'h3, 32'({ref_enable_o, ref_pin_oe_o}));
    bus(1'b0, 2'h3, 32'hFFFF_FFFF);
    chk("unmapped", 32'h0, rd_v);
    chk("queue", 32'h0, exp_q.size());
    // Abort in mid-frame on the second link
    bang({8'h00, 16'hA55A}, 24);
    await_b(1'b1);
    chk("code_b", 32'h0A55A, 32'({mode_b, code_b}));
    bang({8'h03, 16'h1234}, 23);
    await_b(1'b0);
    chk("abort_b", 32'h0A55A, 32'({mode_b, code_b}));
    bang({8'h00, 16'h8001}, 24);
    await_b(1'b1);
    chk("after_abort_b", 32'h08001, 32'({mode_b, code_b}));
    results();
  end
endmodule
